/* File: tmu_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: constants for the timer unit with watchdog
// Assumes: byte addresses on a 32-bit register port
// Notes:   channel field layout shared by channels and watchdog control
//------------------------------------------------------------------------------
package tmu_pkg;
	// -----------------------------------------------------------------
	// register addresses
	// -----------------------------------------------------------------
	localparam logic [31:0] WD_CMP_ADDR = 32'h1000_2000;
	localparam logic [31:0] WD_RUN_ADDR = 32'h1000_2004;
	localparam logic [31:0] WD_CNT_ADDR = 32'h1000_2008;
	localparam logic [31:0] WD_CTRL_ADDR = 32'h1000_200c;
	localparam logic [31:0] RUN_STAT_ADDR = 32'h1000_2010;
	localparam logic [31:0] RUN_SET_ADDR = 32'h1000_2014;
	localparam logic [31:0] RUN_CLR_ADDR = 32'h1000_2018;
	localparam logic [31:0] STOP_STAT_ADDR = 32'h1000_201c;
	localparam logic [31:0] FLAG_ADDR = 32'h1000_2020;
	localparam logic [31:0] FLAG_CLR_ADDR = 32'h1000_2024;
	localparam logic [31:0] STOP_CLR_ADDR = 32'h1000_202c;
	localparam logic [31:0] CH_BASE_ADDR = 32'h1000_2100;
	// per-channel register index, address bits 3:2
	localparam logic [1:0] CH_FULL_IDX = 2'h0;
	localparam logic [1:0] CH_HALF_IDX = 2'h1;
	localparam logic [1:0] CH_CNT_IDX = 2'h2;
	localparam logic [1:0] CH_CTRL_IDX = 2'h3;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int SRC_PCLK_BIT = 0;
	localparam int SRC_RTC_BIT = 1;
	localparam int SRC_XTAL_BIT = 2;
	localparam int DIV_LSB = 3;
	localparam int DIV_MSB = 5;
	localparam int PWM_EN_BIT = 6;
	localparam int INITIAL_OUTPUT_LEVEL_BIT = 7;
	localparam int SD_BIT = 8;
	localparam int CH_CTRL_W = 9;
	localparam int WD_CTRL_W = 6;
	localparam int WD_STOP_BIT = 16;
	localparam int HALF_FLAG_LSB = 16;
	localparam int CH_FIVE = 5;
	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [CH_CTRL_W-1:0] CH_CTRL_RST = 9'h000;
	localparam logic [WD_CTRL_W-1:0] WD_CTRL_RST = 6'h00;
	localparam logic [15:0] CMP_RST = 16'hffff;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// -----------------------------------------------------------------
	// prescaler last count for each divider code
	// -----------------------------------------------------------------
	localparam logic [9:0] DIV_LAST_1 = 10'h000;
	localparam logic [9:0] DIV_LAST_4 = 10'h003;
	localparam logic [9:0] DIV_LAST_16 = 10'h00f;
	localparam logic [9:0] DIV_LAST_64 = 10'h03f;
	localparam logic [9:0] DIV_LAST_256 = 10'h0ff;
	localparam logic [9:0] DIV_LAST_1024 = 10'h3ff;
	localparam logic [2:0] DIV_CODE_MAX = 3'h5;
endpackage : tmu_pkg

/* File: tmu_tick_gen.sv */
//------------------------------------------------------------------------------
// Purpose: counter clock source select and prescaler, one tick per count
// Assumes: crystal and rtc pulses are already synchronised one-cycle edges
// Notes:   reserved divider codes produce no tick
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tmu_tick_gen (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration
	input wire logic [2:0] src_sel,
	input wire logic [2:0] div_code,
	input wire logic run,
	// source pulses
	input wire logic xtal_pulse,
	input wire logic rtc_pulse,
	// counter tick
	output logic tick
);
	import tmu_pkg::*;

	logic [9:0] div_cnt_reg;
	logic [9:0] div_cnt_next;

	// -----------------------------------------------------------------
	// source and divider decode
	// -----------------------------------------------------------------
	// crystal before rtc before bus clock if software sets several
	wire src_pulse = src_sel[SRC_XTAL_BIT] ? xtal_pulse :
		src_sel[SRC_RTC_BIT] ? rtc_pulse : src_sel[SRC_PCLK_BIT];
	wire code_ok = div_code <= DIV_CODE_MAX;
	wire [9:0] div_last = (div_code == 3'h0) ? DIV_LAST_1 :
		(div_code == 3'h1) ? DIV_LAST_4 :
		(div_code == 3'h2) ? DIV_LAST_16 :
		(div_code == 3'h3) ? DIV_LAST_64 :
		(div_code == 3'h4) ? DIV_LAST_256 : DIV_LAST_1024;
	wire div_wrap = div_cnt_reg >= div_last;
	assign tick = run && code_ok && src_pulse && div_wrap;
	assign div_cnt_next = !run ? 10'h000 : !src_pulse ? div_cnt_reg :
		div_wrap ? 10'h000 : div_cnt_reg + 10'h001;

	// -----------------------------------------------------------------
	// prescaler count
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt_reg <= 10'h000;
		end else begin
			div_cnt_reg <= div_cnt_next;
		end
	end

	a_div_ones: assert property (@(posedge clk) disable iff (sys_rst)
		(run && src_pulse && div_code == 3'h0) |-> tick)
		else $error("divide by one did not tick on every source pulse");
endmodule : tmu_tick_gen
`default_nettype wire

/* File: tmu_top.sv */
//------------------------------------------------------------------------------
// Purpose: eight timer channels with pwm, clock stop control and watchdog
// Assumes: inputs synchronous to clk except crystal and rtc clock pins
// Notes:   register port with read data one cycle after the read strobe
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tmu_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [31:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rd_data,
	// slow clock pins
	input wire logic crystal_clock,
	input wire logic rtc_clock,
	// stop requests from the stop-set register
	input wire logic [16:0] stop_set,
	// outputs
	output logic [7:0] pwm_out,
	output logic wd_reset_req
);
	import tmu_pkg::*;

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
	logic rtc_s1_reg, rtc_s2_reg, rtc_s3_reg;
	logic [7:0] ch_stop_reg, ch_stop_next;
	logic wd_stop_reg, wd_stop_next;
	logic [7:0] ch_run_reg, ch_run_next;
	logic [15:0] flag_reg, flag_next;
	logic [15:0] ch_full [0:7];
	logic [15:0] ch_half [0:7];
	logic [15:0] ch_cnt [0:7];
	logic [CH_CTRL_W-1:0] ch_ctrl [0:7];
	logic ch_pwm [0:7];
	logic [7:0] full_hit, half_hit;
	logic [15:0] wd_cmp_reg, wd_cnt_reg;
	logic wd_run_reg, wd_rst_reg;
	logic [WD_CTRL_W-1:0] wd_ctrl_reg;
	logic [31:0] rd_data_reg;
	logic wd_tick;

	// -----------------------------------------------------------------
	// slow clock synchronisers
	// -----------------------------------------------------------------
	// rising edge seen on the second and third stage only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{xtal_s1_reg, xtal_s2_reg, xtal_s3_reg} <= 3'h0;
			{rtc_s1_reg, rtc_s2_reg, rtc_s3_reg} <= 3'h0;
		end else begin
			{xtal_s1_reg, xtal_s2_reg, xtal_s3_reg} <= {crystal_clock, xtal_s1_reg, xtal_s2_reg};
			{rtc_s1_reg, rtc_s2_reg, rtc_s3_reg} <= {rtc_clock, rtc_s1_reg, rtc_s2_reg};
		end
	end
	wire xtal_pulse = xtal_s2_reg && !xtal_s3_reg;
	wire rtc_pulse = rtc_s2_reg && !rtc_s3_reg;

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	wire stop_clr_wr = wr_stb && addr == STOP_CLR_ADDR;
	wire run_set_wr = wr_stb && addr == RUN_SET_ADDR;
	wire run_clr_wr = wr_stb && addr == RUN_CLR_ADDR;
	wire flag_clr_wr = wr_stb && addr == FLAG_CLR_ADDR;
	wire wd_cmp_wr = wr_stb && addr == WD_CMP_ADDR && !wd_stop_reg;
	wire wd_run_wr = wr_stb && addr == WD_RUN_ADDR && !wd_stop_reg;
	wire wd_cnt_wr = wr_stb && addr == WD_CNT_ADDR && !wd_stop_reg;
	wire wd_ctrl_wr = wr_stb && addr == WD_CTRL_ADDR && !wd_stop_reg;
	wire ch_area = addr[31:7] == CH_BASE_ADDR[31:7] && addr[1:0] == 2'h0;
	wire [2:0] ch_idx = addr[6:4];
	wire [1:0] ch_reg = addr[3:2];

	// -----------------------------------------------------------------
	// clock stop bits
	// -----------------------------------------------------------------
	// writes of 0 leave a bit alone; a stop request wins over a clear
	wire [7:0] ch_stop_clr = stop_clr_wr ? wr_data[7:0] : 8'h00;
	wire wd_stop_clr = stop_clr_wr && wr_data[WD_STOP_BIT];
	assign ch_stop_next = (ch_stop_reg & ~ch_stop_clr) | stop_set[7:0];
	assign wd_stop_next = (wd_stop_reg && !wd_stop_clr) || stop_set[WD_STOP_BIT];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ch_stop_reg <= 8'h00;
			wd_stop_reg <= 1'b0;
		end else begin
			ch_stop_reg <= ch_stop_next;
			wd_stop_reg <= wd_stop_next;
		end
	end

	// -----------------------------------------------------------------
	// channel run bits and match flags
	// -----------------------------------------------------------------
	// a stopped channel ignores set and clear
	wire [7:0] run_set = run_set_wr ? wr_data[7:0] & ~ch_stop_reg : 8'h00;
	wire [7:0] run_clr = run_clr_wr ? wr_data[7:0] & ~ch_stop_reg : 8'h00;
	assign ch_run_next = (ch_run_reg | run_set) & ~run_clr;
	wire [15:0] flag_clr = flag_clr_wr ?
		{wr_data[HALF_FLAG_LSB+7:HALF_FLAG_LSB], wr_data[7:0]} : 16'h0000;
	assign flag_next = (flag_reg & ~flag_clr) | {half_hit, full_hit};
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ch_run_reg <= 8'h00;
			flag_reg <= 16'h0000;
		end else begin
			ch_run_reg <= ch_run_next;
			flag_reg <= flag_next;
		end
	end

	// -----------------------------------------------------------------
	// timer channels
	// -----------------------------------------------------------------
	for (genvar i = 0; i < 8; i++) begin : g_ch
		logic tick;
		wire run_ok = ch_run_reg[i] && !ch_stop_reg[i];
		wire wr_me = wr_stb && ch_area && ch_idx == 3'(i) && !ch_stop_reg[i];
		wire half_ok = ch_half[i] <= ch_full[i];
		wire eq_full = ch_cnt[i] == ch_full[i];
		wire eq_half_raw = ch_cnt[i] == ch_half[i];
		wire full_sig = tick && eq_full;
		wire half_sig = tick && eq_half_raw && half_ok;
		wire pwm_en = ch_ctrl[i][PWM_EN_BIT];
		wire initial_output_level = ch_ctrl[i][INITIAL_OUTPUT_LEVEL_BIT];

		tmu_tick_gen u_tick (
			.clk(clk),
			.sys_rst(sys_rst),
			.src_sel(ch_ctrl[i][SRC_XTAL_BIT:SRC_PCLK_BIT]),
			.div_code(ch_ctrl[i][DIV_MSB:DIV_LSB]),
			.run(run_ok),
			.xtal_pulse(xtal_pulse),
			.rtc_pulse(rtc_pulse),
			.tick(tick)
		);

		// channel five flags on plain equality at any time
		assign full_hit[i] = (i == CH_FIVE) ? eq_full : full_sig;
		assign half_hit[i] = (i == CH_FIVE) ? eq_half_raw : half_sig;
		assign pwm_out[i] = ch_pwm[i];

		// configuration and compare values
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ch_full[i] <= CMP_RST;
				ch_half[i] <= CMP_RST;
				ch_ctrl[i] <= CH_CTRL_RST;
			end else if (wr_me) begin
				if (ch_reg == CH_FULL_IDX) ch_full[i] <= wr_data[15:0];
				if (ch_reg == CH_HALF_IDX) ch_half[i] <= wr_data[15:0];
				if (ch_reg == CH_CTRL_IDX) ch_ctrl[i] <= wr_data[CH_CTRL_W-1:0];
			end
		end

		// up counter, wraps after the full match
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ch_cnt[i] <= CNT_RST;
			end else if (wr_me && ch_reg == CH_CNT_IDX) begin
				ch_cnt[i] <= wr_data[15:0];
			end else if (tick) begin
				ch_cnt[i] <= eq_full ? 16'h0000 : ch_cnt[i] + 16'h0001;
			end
		end

		// pwm level: full match restores, half match inverts
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ch_pwm[i] <= 1'b0;
			end else if (!pwm_en) begin
				ch_pwm[i] <= initial_output_level;
			end else if (!run_ok && ch_ctrl[i][SD_BIT]) begin
				ch_pwm[i] <= initial_output_level; // abrupt shutdown
			end else if (full_sig) begin
				ch_pwm[i] <= initial_output_level;
			end else if (half_sig) begin
				ch_pwm[i] <= !initial_output_level;
			end
		end

		a_half_gate: assert property (@(posedge clk) disable iff (sys_rst)
			(ch_half[i] > ch_full[i] && pwm_en && run_ok && !full_sig && !wr_me)
				|=> ch_pwm[i] == $past(ch_pwm[i]))
			else $error("half match with half above full");
		a_pwm_period: assert property (@(posedge clk) disable iff (sys_rst)
			(full_sig && pwm_en && !(wr_me && ch_reg == CH_CNT_IDX)) |=> ch_pwm[i] == $past(initial_output_level)
				&& ch_cnt[i] == 16'h0000)
			else $error("full match did not restart period");
	end

	// -----------------------------------------------------------------
	// watchdog
	// -----------------------------------------------------------------
	wire wd_run_ok = wd_run_reg && !wd_stop_reg;
	wire wd_match = wd_run_ok && wd_cnt_reg == wd_cmp_reg;

	tmu_tick_gen u_wd_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.src_sel(wd_ctrl_reg[SRC_XTAL_BIT:SRC_PCLK_BIT]),
		.div_code(wd_ctrl_reg[DIV_MSB:DIV_LSB]),
		.run(wd_run_ok),
		.xtal_pulse(xtal_pulse),
		.rtc_pulse(rtc_pulse),
		.tick(wd_tick)
	);

	// watchdog registers, upper control bits dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_cmp_reg <= CMP_RST;
			wd_run_reg <= 1'b0;
			wd_ctrl_reg <= WD_CTRL_RST;
		end else begin
			if (wd_cmp_wr) wd_cmp_reg <= wr_data[15:0];
			if (wd_run_wr) wd_run_reg <= wr_data[0];
			if (wd_ctrl_wr) wd_ctrl_reg <= wr_data[WD_CTRL_W-1:0];
		end
	end

	// 16-bit up counter on the prescaler tick
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_cnt_reg <= CNT_RST;
		end else if (wd_cnt_wr) begin
			wd_cnt_reg <= wr_data[15:0];
		end else if (wd_tick) begin
			wd_cnt_reg <= wd_cnt_reg + 16'h0001;
		end
	end

	// reset request sticks until system reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_rst_reg <= 1'b0;
		end else if (wd_match) begin
			wd_rst_reg <= 1'b1;
		end
	end
	assign wd_reset_req = wd_rst_reg;

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	wire [15:0] ch_rd_val = ch_stop_reg[ch_idx] ? 16'h0000 :
		(ch_reg == CH_FULL_IDX) ? ch_full[ch_idx] :
		(ch_reg == CH_HALF_IDX) ? ch_half[ch_idx] :
		(ch_reg == CH_CNT_IDX) ? ch_cnt[ch_idx] :
		{{(16-CH_CTRL_W){1'b0}}, ch_ctrl[ch_idx]};
	wire [31:0] flag_rd = {8'h00, flag_reg[15:8], 8'h00, flag_reg[7:0]};
	wire [31:0] stop_rd = {15'h0000, wd_stop_reg, 8'h00, ch_stop_reg};
	wire [31:0] wd_rd = (addr == WD_CMP_ADDR) ? {16'h0000, wd_cmp_reg} :
		(addr == WD_RUN_ADDR) ? {31'h0, wd_run_reg} :
		(addr == WD_CNT_ADDR) ? {16'h0000, wd_cnt_reg} :
		{26'h0, wd_ctrl_reg};
	wire wd_area = addr[31:4] == WD_CMP_ADDR[31:4] && addr[1:0] == 2'h0;
	wire [31:0] rd_mux = (wd_area && !wd_stop_reg) ? wd_rd :
		ch_area ? {16'h0000, ch_rd_val} :
		(addr == RUN_STAT_ADDR) ? {24'h0, ch_run_reg} :
		(addr == STOP_STAT_ADDR) ? stop_rd :
		(addr == FLAG_ADDR) ? flag_rd : 32'h0000_0000;

	// read data stand one cycle only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_reg <= 32'h0000_0000;
		end else begin
			rd_data_reg <= rd_stb ? rd_mux : 32'h0000_0000;
		end
	end
	assign rd_data = rd_data_reg;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_stop_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_clr_wr && stop_set == 17'h0) |=>
			(ch_stop_reg & $past(wr_data[7:0])) == 8'h00)
		else $error("channel stop bit not cleared");
	a_stop_keep: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_clr_wr && stop_set == 17'h0) |=>
			(ch_stop_reg & ~$past(wr_data[7:0])) == ($past(ch_stop_reg) & ~$past(wr_data[7:0])))
		else $error("stop bit changed by a zero write");
	a_wd_unstop: assert property (@(posedge clk) disable iff (sys_rst)
		(stop_clr_wr && wr_data[16] && !stop_set[16]) |=> !wd_stop_reg)
		else $error("watchdog stop bit not cleared");
	a_start_bit: assert property (@(posedge clk) disable iff (sys_rst)
		(run_set_wr && wr_data[0] && !ch_stop_reg[0]) |=> ch_run_reg[0])
		else $error("channel did not start");
	a_halt_bit: assert property (@(posedge clk) disable iff (sys_rst)
		(run_clr_wr && wr_data[7] && !ch_stop_reg[7]) |=> !ch_run_reg[7])
		else $error("channel did not stop");
	a_five_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(ch_cnt[5] == ch_full[5] || ch_cnt[5] == ch_half[5]) |=>
			(flag_reg[5] || flag_reg[13]))
		else $error("channel five flag missed");
	a_wd_request: assert property (@(posedge clk) disable iff (sys_rst)
		wd_match |=> wd_reset_req [*3])
		else $error("watchdog reset request late or dropped");
	a_wd_cause: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(wd_reset_req) |-> $past(wd_cnt_reg == wd_cmp_reg && wd_run_ok))
		else $error("watchdog reset without a match");
	a_wd_gated: assert property (@(posedge clk) disable iff (sys_rst)
		(wd_stop_reg && !wd_cnt_wr) |=> wd_cnt_reg == $past(wd_cnt_reg))
		else $error("stopped watchdog counted");
	a_wd_upper: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_stb && addr == WD_CTRL_ADDR) |=> rd_data[31:6] == 26'h0)
		else $error("watchdog control upper bits not zero");
endmodule : tmu_top
`default_nettype wire

/* File: test_tmu_top.sv */
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the timer unit with watchdog
// Assumes: read data sampled at the falling edge of the cycle it stands in
// Notes:   slow clock pins run free at rates unrelated to the bus clock
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module test_tmu_top;
	import tmu_pkg::*;
	// -----------------------------------------------------------------
	// stimulus, clocks and device
	// -----------------------------------------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] addr = 32'h0;
	logic [31:0] wr_data = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [31:0] rd_data;
	logic crystal_clock = 1'b0;
	logic rtc_clock = 1'b0;
	logic [16:0] stop_set = 17'h0;
	logic [7:0] pwm_out;
	logic wd_reset_req;
	logic [31:0] v;
	int fails = 0;
	int comparisons = 0;
	// bus clock and free running slow pins
	always #4 clk = ~clk;
	always #100.3 crystal_clock = ~crystal_clock;
	always #500.7 rtc_clock = ~rtc_clock;
	tmu_top DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .crystal_clock(crystal_clock),
		.rtc_clock(rtc_clock), .stop_set(stop_set), .pwm_out(pwm_out),
		.wd_reset_req(wd_reset_req));
	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	// compare within a tolerance, unknowns never match
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
		logic ok;
		ok = (g === e) || (t > 0 && g + t >= e && g <= e + t);
		comparisons++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		d = rd_data;
	endtask : rd
	task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
		rd(a, v);
		chk(nm, e, v, 0);
	endtask : rc
	function automatic logic [31:0] cha(input int n, input logic [1:0] idx);
		return CH_BASE_ADDR + 32'(n * 16) + {28'h0, idx, 2'b00};
	endfunction : cha
	task automatic do_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
	endtask : do_reset
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_regs();
		rc("wd ctrl rst", WD_CTRL_ADDR, 32'h0);
		rc("wd run rst", WD_RUN_ADDR, 32'h0);
		rc("stop rst", STOP_STAT_ADDR, 32'h0);
		wr(WD_CTRL_ADDR, 32'hffff_ffc0);
		rc("wd ctrl upper", WD_CTRL_ADDR, 32'h0);
		wr(WD_CTRL_ADDR, 32'h2f);
		rc("wd ctrl fields", WD_CTRL_ADDR, 32'h2f);
		wr(WD_RUN_ADDR, 32'hfe);
		rc("wd run upper", WD_RUN_ADDR, 32'h0);
		rc("unmapped", 32'h1000_2030, 32'h0);
		wr(WD_CTRL_ADDR, 32'h0);
		$display("regs done");
	endtask : t_regs
	task automatic t_stop();
		@(posedge clk);
		stop_set <= 17'h1_0009;
		@(posedge clk);
		stop_set <= 17'h0;
		rc("stop set", STOP_STAT_ADDR, 32'h1_0009);
		wr(WD_CMP_ADDR, 32'h1234);
		rc("stopped read", WD_CMP_ADDR, 32'h0);
		wr(STOP_CLR_ADDR, 32'h1_0001);
		rc("stop clr", STOP_STAT_ADDR, 32'h8);
		rc("stopped write", WD_CMP_ADDR, {16'h0, CMP_RST});
		wr(STOP_CLR_ADDR, 32'h6);
		rc("zero ignored", STOP_STAT_ADDR, 32'h8);
		wr(STOP_CLR_ADDR, 32'hffff_ffff);
		rc("stop all clr", STOP_STAT_ADDR, 32'h0);
		$display("stop done");
	endtask : t_stop
	// counter steps per divider code and per source, reserved codes stand still
	task automatic t_wd_rate();
		logic [31:0] ctl [10] = '{32'h01, 32'h09, 32'h11, 32'h19, 32'h21, 32'h29, 32'h31,
			32'h39, 32'h04, 32'h02};
		int per [10] = '{1, 4, 16, 64, 256, 1024, 0, 0, 25, 125};
		logic [31:0] a;
		logic [31:0] e;
		wr(WD_RUN_ADDR, 32'h1);
		for (int i = 0; i < 10; i++) begin
			wr(WD_CTRL_ADDR, ctl[i]);
			rd(WD_CNT_ADDR, a);
			e = (per[i] == 0) ? 32'h0 : 32'((4 * per[i] + 2) / per[i]);
			repeat ((per[i] == 0) ? 64 : 4 * per[i]) @(posedge clk);
			rd(WD_CNT_ADDR, v);
			chk("wd step", e, v - a, (per[i] == 0) ? 0 : 1);
		end
		wr(WD_RUN_ADDR, 32'h0);
		wr(WD_CTRL_ADDR, 32'h01);
		rd(WD_CNT_ADDR, a);
		repeat (8) @(posedge clk);
		rc("wd held", WD_CNT_ADDR, a);
		$display("wd rate done");
	endtask : t_wd_rate
	task automatic t_wd_reset();
		int n = 0;
		wr(WD_CMP_ADDR, 32'd20);
		wr(WD_CNT_ADDR, 32'h0);
		wr(WD_RUN_ADDR, 32'h1);
		while (wd_reset_req !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk("wd req delay", 32'd22, 32'(n), 3);
		if (n >= 60) tally_and_finish();
		repeat (8) @(negedge clk);
		chk("wd req held", 32'h1, {31'h0, wd_reset_req}, 0);
		do_reset();
		@(negedge clk);
		chk("wd req rst", 32'h0, {31'h0, wd_reset_req}, 0);
		rc("wd ctrl rst2", WD_CTRL_ADDR, 32'h0);
		$display("wd reset done");
	endtask : t_wd_reset
	// pwm on one channel: highs and level changes over 20 cycles
	task automatic t_pwm(input int ch, input logic [31:0] fu, input logic [31:0] ha,
		input int hi, input int fl);
		int h = 0;
		int f = 0;
		logic p;
		wr(cha(ch, CH_CTRL_IDX), 32'h100);
		wr(cha(ch, CH_FULL_IDX), fu);
		wr(cha(ch, CH_HALF_IDX), ha);
		wr(cha(ch, CH_CNT_IDX), 32'h0);
		wr(cha(ch, CH_CTRL_IDX), 32'h141);
		wr(RUN_SET_ADDR, 32'h1 << ch);
		rc("run set", RUN_STAT_ADDR, 32'h1 << ch);
		p = pwm_out[ch];
		repeat (20) begin
			@(negedge clk);
			h += (pwm_out[ch] === 1'b1) ? 1 : 0;
			f += (pwm_out[ch] !== p) ? 1 : 0;
			p = pwm_out[ch];
		end
		chk("pwm highs", 32'(hi), 32'(h), 0);
		chk("pwm flips", 32'(fl), 32'(f), 0);
		wr(RUN_CLR_ADDR, 32'h1 << ch);
		rc("run clr", RUN_STAT_ADDR, 32'h0);
		chk("pwm idle", 32'h0, {31'h0, pwm_out[ch]}, 0);
		$display("pwm done");
	endtask : t_pwm
	task automatic t_flags();
		wr(cha(1, CH_CTRL_IDX), 32'h100);
		wr(cha(1, CH_FULL_IDX), 32'h3);
		wr(cha(1, CH_HALF_IDX), 32'h5);
		wr(cha(1, CH_CNT_IDX), 32'h4);
		wr(cha(1, CH_CTRL_IDX), 32'h141);
		wr(FLAG_CLR_ADDR, 32'hffff_ffff);
		wr(RUN_SET_ADDR, 32'h2);
		repeat (20) @(posedge clk);
		wr(RUN_CLR_ADDR, 32'h2);
		rc("half over full", FLAG_ADDR, 32'h0);
		wr(cha(1, CH_CNT_IDX), 32'h3);
		wr(RUN_SET_ADDR, 32'h2);
		wr(RUN_CLR_ADDR, 32'h2);
		rc("full flag", FLAG_ADDR, 32'h2);
		wr(cha(5, CH_CTRL_IDX), 32'h100);
		wr(cha(5, CH_FULL_IDX), 32'h7);
		wr(cha(5, CH_HALF_IDX), 32'h0);
		wr(cha(5, CH_CTRL_IDX), 32'h101);
		wr(cha(5, CH_CNT_IDX), 32'h0);
		wr(cha(5, CH_CTRL_IDX), 32'h100);
		wr(FLAG_CLR_ADDR, 32'hffff_ffff);
		rc("ch5 half eq", FLAG_ADDR, 32'h20_0000);
		wr(cha(5, CH_HALF_IDX), 32'h3);
		wr(FLAG_CLR_ADDR, 32'h20_0000);
		rc("ch5 cleared", FLAG_ADDR, 32'h0);
		wr(cha(5, CH_FULL_IDX), 32'h0);
		rc("ch5 full eq", FLAG_ADDR, 32'h20);
		$display("flags done");
	endtask : t_flags
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_stop();
		t_wd_rate();
		t_wd_reset();
		t_pwm(0, 32'h1, 32'h0, 10, 20);
		t_pwm(2, 32'h4, 32'h1, 12, 8);
		t_flags();
		tally_and_finish();
	end
endmodule : test_tmu_top
`default_nettype wire
